/* mfd_decoder.sv */
// Microword field decoder with its AXI4-Lite control and status registers.
//
// Functional notes
// - Bits 23..21 pick R-bus source: 011 fence, 001 B, 000 A, 110 reserved.
// - Code 101 follows addressable flip-flops; neither set gives A unless qualified source.
// - Code 100 reads A when instruction bit 11 is zero, else B.
// - With no R-bus source selected the R-bus is all zeros.
// - Bits 20..17 pick S-bus source: PC, scratch one/three/four, M, T, I/O input.
// - Bits 16..12 give function: logic, add, increment, microjumps, subroutine call.
// - Bits 11..8 give store destination: A, B, fence, PC, instruction, T, M.
// - Bits 7..4 give special: memory, I/O group, alter-skip, carry tests, shifts.
// - Bits 3..0 give skip condition: always, end, counter, flag, negative, odd, repeat.
// - All-ones fields do nothing, except function all-ones performs inclusive OR.
// - Code x111 gives qualified source, circular shift, scratch one, load enable, bit zero.
// - Code x101 gives loop count, return, scratch three, shift group two, overflow.
// - Code x000 gives interrupt code, call, I/O output, reverse skip, bump count.
// - Q on R-bus 010 and store 1010; other x010 codes per field.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "mfd_params.svh"

module mfd_decoder (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic [`MFD_WORD_W-1:0]    microword,
  input  wire logic                      microword_valid,
  input  wire logic                      addr_a_ff,
  input  wire logic                      addr_b_ff,
  input  wire logic                      instruction_reg_bit11,
  input  wire logic [`MFD_DATA_W-1:0]    reg_a,
  input  wire logic [`MFD_DATA_W-1:0]    reg_b,
  input  wire logic [`MFD_DATA_W-1:0]    reg_fence,
  input  wire logic [`MFD_DATA_W-1:0]    reg_q,
  output mfd_pkg::mfd_decode_s           decode,
  output logic      [`MFD_DATA_W-1:0]    rbus_data,
  input  wire logic [`MFD_ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [`MFD_ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import mfd_pkg::*;

  // ****************************************
  // Field decode functions
  // ****************************************

  // R-bus source from the three-bit code and the qualifying inputs.
  function automatic mfd_rsrc_e dec_rbus(input logic [2:0] code, input logic qual,
                                         input logic ffa, input logic ffb,
                                         input logic ib11);
    mfd_rsrc_e r;
    r = MFD_R_NONE;
    unique case (code)
      3'h0: r = MFD_R_A;
      3'h1: r = MFD_R_B;
      3'h2: r = MFD_R_Q;
      3'h3: r = MFD_R_FENCE;
      3'h4: r = ib11 ? MFD_R_B : MFD_R_A;
      3'h5: begin
        if (ffb) begin
          r = MFD_R_B;
        end else if (ffa || !qual) begin
          r = MFD_R_A;
        end else begin
          r = MFD_R_NONE;
        end
      end
      3'h6: r = MFD_R_NONE;
      3'h7: r = MFD_R_NONE;
    endcase
    return r;
  endfunction

  // S-bus source from the four-bit code.
  function automatic mfd_ssrc_e dec_sbus(input logic [3:0] code);
    mfd_ssrc_e s;
    case (code)
      4'hE:    s = MFD_S_PC;
      4'hB:    s = MFD_S_SCRATCH_REG_ONE;
      4'hA:    s = MFD_S_SCRATCH_REG_TWO;
      4'h9:    s = MFD_S_SCRATCH_REG_THREE;
      4'h8:    s = MFD_S_SCRATCH_REG_FOUR;
      4'h7:    s = MFD_S_QUALIFIED_SOURCE;
      4'h5:    s = MFD_S_LOOP_COUNT_REGISTER;
      4'h3:    s = MFD_S_M;
      4'h2:    s = MFD_S_T;
      4'h1:    s = MFD_S_IO_INPUT_BUS;
      4'h0:    s = MFD_S_INTERRUPT_CODE_REGISTER;
      default: s = MFD_S_NONE;
    endcase
    return s;
  endfunction

  // Function operation from the five-bit code.
  function automatic mfd_func_e dec_func(input logic [4:0] code);
    mfd_func_e f;
    case (code)
      5'h1F:       f = MFD_F_INCLUSIVE_OR_OP;
      5'h0E:       f = MFD_F_XOR;
      5'h0D:       f = MFD_F_NOR;
      5'h0C:       f = MFD_F_AND;
      5'h0B:       f = MFD_F_ADD;
      5'h0A:       f = MFD_F_SUM_OVERFLOW_VARIANT;
      5'h09:       f = MFD_F_INC;
      5'h13, 5'h12: f = MFD_F_MICROJUMP;
      5'h11:       f = MFD_F_MICRO_SUBROUTINE_CALL;
      5'h10:       f = MFD_F_MICRO_SUBROUTINE_CALL;
      5'h17:       f = MFD_F_CIRCULAR_RIGHT_SHIFT;
      5'h15:       f = MFD_F_MICRO_RETURN;
      5'h1A:       f = MFD_F_WORD_FLAG_LOAD;
      default:     f = MFD_F_NONE;
    endcase
    return f;
  endfunction

  // Store destination from the four-bit code.
  function automatic mfd_store_e dec_store(input logic [3:0] code);
    mfd_store_e d;
    case (code)
      4'hE:    d = MFD_D_A;
      4'hD:    d = MFD_D_B;
      4'hA:    d = MFD_D_Q;
      4'h9:    d = MFD_D_FENCE;
      4'h8:    d = MFD_D_PC;
      4'h7:    d = MFD_D_SCRATCH_REG_ONE;
      4'h6:    d = MFD_D_SCRATCH_REG_TWO;
      4'h5:    d = MFD_D_SCRATCH_REG_THREE;
      4'h4:    d = MFD_D_SCRATCH_REG_FOUR;
      4'h3:    d = MFD_D_INSTRUCTION_REG;
      4'h2:    d = MFD_D_T;
      4'h1:    d = MFD_D_M;
      4'h0:    d = MFD_D_IO_OUTPUT_BUS;
      default: d = MFD_D_NONE;
    endcase
    return d;
  endfunction

  // Special operation from the four-bit code.
  function automatic mfd_spec_e dec_spec(input logic [3:0] code);
    mfd_spec_e p;
    case (code)
      4'hE:    p = MFD_P_MEM_RW;
      4'hD:    p = MFD_P_IO_GROUP_ONE;
      4'hB:    p = MFD_P_ALTER_SKIP_GROUP_TWO;
      4'hA:    p = MFD_P_ALTER_SKIP_GROUP_ONE;
      4'h9:    p = MFD_P_EXTEND_CARRY_TEST_A;
      4'h8:    p = MFD_P_EXTEND_CARRY_TEST_B;
      4'h7:    p = MFD_P_SPECIAL_LOAD_ENABLE;
      4'h5:    p = MFD_P_SHIFT_ROTATE_GROUP_TWO;
      4'h3:    p = MFD_P_LOOP_COUNT_LOAD;
      4'h2:    p = MFD_P_RIGHT_BY_ONE;
      4'h1:    p = MFD_P_LEFT_BY_ONE;
      4'h0:    p = MFD_P_REVERSE_SKIP_SENSE;
      default: p = MFD_P_NONE;
    endcase
    return p;
  endfunction

  // Skip condition from the four-bit code.
  function automatic mfd_skip_e dec_skip(input logic [3:0] code);
    mfd_skip_e k;
    case (code)
      4'hE:    k = MFD_K_ALWAYS_SKIP;
      4'hD:    k = MFD_K_END_OF_OPERATION_SKIP;
      4'hA:    k = MFD_K_NO_PROTECT_VIOLATION_SKIP;
      4'h9:    k = MFD_K_COUNTER_DONE_SKIP;
      4'h8:    k = MFD_K_COUNTER_DONE_BUMP_SKIP;
      4'h7:    k = MFD_K_TEST_BIT_ZERO;
      4'h6:    k = MFD_K_FLAG_SKIP;
      4'h5:    k = MFD_K_OVERFLOW_SKIP;
      4'h3:    k = MFD_K_NEGATIVE_SKIP;
      4'h2:    k = MFD_K_ODD;
      4'h1:    k = MFD_K_REPEAT_SKIP;
      4'h0:    k = MFD_K_BUMP_COUNT_SKIP;
      default: k = MFD_K_NONE;
    endcase
    return k;
  endfunction

  // ****************************************
  // Decode path
  // ****************************************

  logic                     ctrl_en_reg;
  logic [`MFD_WORD_W-1:0]   last_word_reg;
  logic [31:0]              count_reg;
  mfd_decode_s              decode_reg;
  mfd_decode_s              decode_next;
  logic [`MFD_DATA_W-1:0]   rbus_reg;
  logic [`MFD_DATA_W-1:0]   rbus_next;
  wire                      take_word;
  wire  [3:0]               sbus_code;

  // A word is decoded only when the store marks it valid and software allows decoding.
  assign take_word = microword_valid && ctrl_en_reg;
  assign sbus_code = microword[`MFD_SBUS_HI:`MFD_SBUS_LO];

  // All six fields are decoded side by side from the same word.
  assign decode_next = take_word ? mfd_decode_s'{
      rsrc:  dec_rbus(microword[`MFD_RBUS_HI:`MFD_RBUS_LO], sbus_code == 4'h7,
                      addr_a_ff, addr_b_ff, instruction_reg_bit11),
      ssrc:  dec_sbus(sbus_code),
      func:  dec_func(microword[`MFD_FUNC_HI:`MFD_FUNC_LO]),
      store: dec_store(microword[`MFD_STORE_HI:`MFD_STORE_LO]),
      spec:  dec_spec(microword[`MFD_SPEC_HI:`MFD_SPEC_LO]),
      skip:  dec_skip(microword[`MFD_SKIP_HI:`MFD_SKIP_LO])}
    : mfd_decode_s'{MFD_R_NONE, MFD_S_NONE, MFD_F_NONE, MFD_D_NONE, MFD_P_NONE, MFD_K_NONE};

  // R-bus mux; an idle selection leaves every bit low.
  assign rbus_next = (decode_next.rsrc == MFD_R_A)     ? reg_a     :
                     (decode_next.rsrc == MFD_R_B)     ? reg_b     :
                     (decode_next.rsrc == MFD_R_FENCE) ? reg_fence :
                     (decode_next.rsrc == MFD_R_Q)     ? reg_q     :
                     {`MFD_DATA_W{1'b0}};

  // Decoded selections and bus data are registered for the datapath.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      decode_reg <= '{MFD_R_NONE, MFD_S_NONE, MFD_F_NONE, MFD_D_NONE, MFD_P_NONE,
                      MFD_K_NONE};
      rbus_reg   <= 16'h0000;
    end else begin
      decode_reg <= decode_next;
      rbus_reg   <= rbus_next;
    end
  end

  // Last accepted word and a running count of decoded words for software.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_word_reg <= 24'h00_0000;
      count_reg     <= 32'h0000_0000;
    end else if (take_word) begin
      last_word_reg <= microword;
      count_reg     <= count_reg + 32'h0000_0001;
    end
  end

  assign decode    = decode_reg;
  assign rbus_data = rbus_reg;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************

  logic                   aw_hold_reg;
  logic [`MFD_ADDR_W-1:0] aw_addr_reg;
  logic                   w_hold_reg;
  logic [31:0]            w_data_reg;
  logic                   w_strb0_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  wire                    aw_fire;
  wire                    w_fire;
  wire                    do_write;
  wire                    ar_fire;
  wire                    wr_ctrl;
  wire                    rd_hit;
  wire  [31:0]            rd_mux;

  // Address and data are taken independently; the write completes once both are held.
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_ctrl       = do_write && (aw_addr_reg[`MFD_ADDR_W-1:2] == 2'h0);

  // Read decode; unmapped offsets answer zero with an error response.
  assign s_axi_arready = !rvalid_reg;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_hit        = s_axi_araddr[`MFD_ADDR_W-1:2] <= 2'h2;
  assign rd_mux = (s_axi_araddr[`MFD_ADDR_W-1:2] == 2'h0) ? {31'h0000_0000, ctrl_en_reg} :
                  (s_axi_araddr[`MFD_ADDR_W-1:2] == 2'h1) ? {8'h00, last_word_reg} :
                  (s_axi_araddr[`MFD_ADDR_W-1:2] == 2'h2) ? count_reg :
                  32'h0000_0000;

  // Write channel holding registers and response.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MFD_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ctrl ? `MFD_RESP_OKAY : `MFD_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
      end
    end
  end

  // Control register: bit 0 allows decoding.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_en_reg <= `MFD_CTRL_RST;
    end else if (wr_ctrl && w_strb0_reg) begin
      ctrl_en_reg <= w_data_reg[0];
    end
  end

  // Read channel: data is registered and held until taken.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `MFD_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? `MFD_RESP_OKAY : `MFD_RESP_SLVERR;
      rdata_reg  <= rd_mux;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

endmodule

/* mfd_decoder_asserts.sv */
// Concurrent checks on the decoded selections and the R-bus of the decoder.
`timescale 1ns/100ps
`include "mfd_params.svh"

module mfd_decoder_asserts (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic [`MFD_WORD_W-1:0] microword,
  input wire logic                   microword_valid,
  input wire logic                   addr_b_ff,
  input wire logic                   instruction_reg_bit11,
  input wire logic [`MFD_DATA_W-1:0] reg_a,
  input wire logic [`MFD_DATA_W-1:0] reg_b,
  input wire logic [`MFD_DATA_W-1:0] reg_fence,
  input wire logic [`MFD_DATA_W-1:0] reg_q,
  input wire mfd_pkg::mfd_decode_s   decode,
  input wire logic [`MFD_DATA_W-1:0] rbus_data
);
  import mfd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // R-bus code of the presented word and which of A or B it asks for.
  wire logic [2:0] rcode  = microword[23:21];
  wire logic       pick_b = rcode == 3'h1 || rcode == 3'h5 && addr_b_ff
                            || rcode == 3'h4 && instruction_reg_bit11;
  wire logic       pick_a = rcode == 3'h0 || rcode == 3'h5 && !addr_b_ff
                            || rcode == 3'h4 && !instruction_reg_bit11;
  // Each decoded selection must trace back to the word seen one edge earlier.
  a_rbus_idle_zero: assert property (decode.rsrc == MFD_R_NONE |-> rbus_data == 16'h0000)
    else $error("rbus not zero without source");
  a_fence_source: assert property (decode.rsrc == MFD_R_FENCE |->
    $past(rcode) == 3'h3 && rbus_data == $past(reg_fence)) else $error("bad fence read");
  a_q_source: assert property (decode.rsrc == MFD_R_Q |->
    $past(rcode) == 3'h2 && rbus_data == $past(reg_q)) else $error("bad q read");
  a_b_source: assert property (decode.rsrc == MFD_R_B |->
    $past(pick_b) && rbus_data == $past(reg_b)) else $error("bad b read");
  a_a_source: assert property (decode.rsrc == MFD_R_A |->
    $past(pick_a) && rbus_data == $past(reg_a)) else $error("bad a read");
  a_invalid_idle: assert property (!$past(microword_valid) |-> decode == '0)
    else $error("decode active for invalid word");
  a_ones_quiet: assert property ($past(microword_valid) &&
    $past(microword) == 24'hFF_FFFF |->
    {decode.rsrc, decode.ssrc, decode.store, decode.spec, decode.skip} == '0)
    else $error("all-ones word not quiet");
  a_ones_or: assert property (decode.func == MFD_F_INCLUSIVE_OR_OP |->
    $past(microword[16:12]) == 5'h1F) else $error("bad inclusive or");
  a_odd_skip: assert property (decode.skip == MFD_K_ODD |->
    $past(microword[3:0]) == 4'h2) else $error("bad odd skip");
  a_store_q: assert property (decode.store == MFD_D_Q |->
    $past(microword[11:8]) == 4'hA) else $error("bad q store");
  c_rbus_b: cover property (decode.rsrc == MFD_R_B);
  c_qualified: cover property (decode.ssrc == MFD_S_QUALIFIED_SOURCE);
  c_or_func: cover property (decode.func == MFD_F_INCLUSIVE_OR_OP);
endmodule

bind mfd_decoder mfd_decoder_asserts mfd_decoder_asserts_inst (.*);

/* mfd_params.svh */
// Constants for the microword field decoder: field positions, offsets, reset values.
`ifndef MFD_PARAMS_SVH
`define MFD_PARAMS_SVH

// ****************************************
// Microword layout
// ****************************************
`define MFD_WORD_W      24
`define MFD_DATA_W      16
`define MFD_RBUS_HI     23
`define MFD_RBUS_LO     21
`define MFD_SBUS_HI     20
`define MFD_SBUS_LO     17
`define MFD_FUNC_HI     16
`define MFD_FUNC_LO     12
`define MFD_STORE_HI    11
`define MFD_STORE_LO    8
`define MFD_SPEC_HI     7
`define MFD_SPEC_LO     4
`define MFD_SKIP_HI     3
`define MFD_SKIP_LO     0

// ****************************************
// Register map and reset values
// ****************************************
`define MFD_ADDR_W      4
`define MFD_OFS_CTRL    4'h0
`define MFD_OFS_LAST    4'h4
`define MFD_OFS_COUNT   4'h8
`define MFD_CTRL_RST    1'h1
`define MFD_RESP_OKAY   2'h0
`define MFD_RESP_SLVERR 2'h2

`endif

/* mfd_pkg.sv */
// Types shared by the microword field decoder.
package mfd_pkg;

  // R-bus source selection.
  typedef enum logic [2:0] {
    MFD_R_NONE, MFD_R_A, MFD_R_B, MFD_R_FENCE, MFD_R_Q
  } mfd_rsrc_e;

  // S-bus source selection.
  typedef enum logic [3:0] {
    MFD_S_NONE, MFD_S_PC, MFD_S_SCRATCH_REG_ONE, MFD_S_SCRATCH_REG_TWO,
    MFD_S_SCRATCH_REG_THREE, MFD_S_SCRATCH_REG_FOUR, MFD_S_QUALIFIED_SOURCE,
    MFD_S_LOOP_COUNT_REGISTER, MFD_S_M, MFD_S_T, MFD_S_IO_INPUT_BUS,
    MFD_S_INTERRUPT_CODE_REGISTER
  } mfd_ssrc_e;

  // Function operation.
  typedef enum logic [3:0] {
    MFD_F_NONE, MFD_F_INCLUSIVE_OR_OP, MFD_F_XOR, MFD_F_NOR, MFD_F_AND,
    MFD_F_ADD, MFD_F_SUM_OVERFLOW_VARIANT, MFD_F_INC, MFD_F_MICROJUMP,
    MFD_F_MICRO_SUBROUTINE_CALL, MFD_F_CIRCULAR_RIGHT_SHIFT, MFD_F_MICRO_RETURN,
    MFD_F_WORD_FLAG_LOAD
  } mfd_func_e;

  // Store destination.
  typedef enum logic [3:0] {
    MFD_D_NONE, MFD_D_A, MFD_D_B, MFD_D_FENCE, MFD_D_PC, MFD_D_INSTRUCTION_REG,
    MFD_D_T, MFD_D_M, MFD_D_SCRATCH_REG_ONE, MFD_D_SCRATCH_REG_TWO,
    MFD_D_SCRATCH_REG_THREE, MFD_D_SCRATCH_REG_FOUR, MFD_D_IO_OUTPUT_BUS, MFD_D_Q
  } mfd_store_e;

  // Special operation.
  typedef enum logic [3:0] {
    MFD_P_NONE, MFD_P_MEM_RW, MFD_P_IO_GROUP_ONE, MFD_P_ALTER_SKIP_GROUP_TWO,
    MFD_P_EXTEND_CARRY_TEST_A, MFD_P_EXTEND_CARRY_TEST_B, MFD_P_LOOP_COUNT_LOAD,
    MFD_P_RIGHT_BY_ONE, MFD_P_LEFT_BY_ONE, MFD_P_SPECIAL_LOAD_ENABLE,
    MFD_P_SHIFT_ROTATE_GROUP_TWO, MFD_P_REVERSE_SKIP_SENSE,
    MFD_P_ALTER_SKIP_GROUP_ONE
  } mfd_spec_e;

  // Skip condition.
  typedef enum logic [3:0] {
    MFD_K_NONE, MFD_K_ALWAYS_SKIP, MFD_K_END_OF_OPERATION_SKIP,
    MFD_K_COUNTER_DONE_SKIP, MFD_K_COUNTER_DONE_BUMP_SKIP, MFD_K_FLAG_SKIP,
    MFD_K_NEGATIVE_SKIP, MFD_K_ODD, MFD_K_REPEAT_SKIP, MFD_K_TEST_BIT_ZERO,
    MFD_K_OVERFLOW_SKIP, MFD_K_BUMP_COUNT_SKIP, MFD_K_NO_PROTECT_VIOLATION_SKIP
  } mfd_skip_e;

  // All six decoded selections of one microword.
  typedef struct packed {
    mfd_rsrc_e  rsrc;
    mfd_ssrc_e  ssrc;
    mfd_func_e  func;
    mfd_store_e store;
    mfd_spec_e  spec;
    mfd_skip_e  skip;
  } mfd_decode_s;

endpackage

/* mfd_store_model.sv */
// Behavioural microcode store and register datapath facing the decoder.
`timescale 1ns/100ps

module mfd_store_model #(
  parameter logic [15:0] A_VAL = 16'h1111,
  parameter logic [15:0] B_VAL = 16'h2222,
  parameter logic [15:0] F_VAL = 16'h3333,
  parameter logic [15:0] Q_VAL = 16'h4444
) (
  input  wire logic [23:0] pm_word,
  input  wire logic        pm_valid,
  output logic      [23:0] microword,
  output logic             microword_valid,
  output logic      [15:0] reg_a,
  output logic      [15:0] reg_b,
  output logic      [15:0] reg_fence,
  output logic      [15:0] reg_q
);
  // A whole word is held for the cycle; outside valid cycles the lines show its inverse.
  assign microword       = pm_valid ? pm_word : ~pm_word;
  assign microword_valid = pm_valid;
  // Register contents offered to the R-bus selector.
  assign reg_a     = A_VAL;
  assign reg_b     = B_VAL;
  assign reg_fence = F_VAL;
  assign reg_q     = Q_VAL;
endmodule

/* tb.sv */
// Self-checking bench for the microword field decoder.
`timescale 1ns/100ps
`include "mfd_params.svh"

module tb;
  import mfd_pkg::*;
  typedef struct {logic [23:0] w; mfd_decode_s d; logic [15:0] r;} mfd_row_s;
  localparam logic [15:0] VA = 16'h1111;
  localparam logic [15:0] VB = 16'h2222;
  logic        mclk, rst_n, microword_valid, addr_a_ff, addr_b_ff, instruction_reg_bit11;
  logic        pm_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [23:0] microword, pm_word;
  logic [15:0] reg_a, reg_b, reg_fence, reg_q, rbus_data;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  mfd_decode_s decode;
  int          n_errors = 0;
  int          comparisons = 0;
  // Ordinary decodes: word, expected selections, expected R-bus.
  mfd_row_s rows [14] = '{
    '{24'hFF_FFFF, '{MFD_R_NONE, MFD_S_NONE, MFD_F_INCLUSIVE_OR_OP, MFD_D_NONE, MFD_P_NONE,
      MFD_K_NONE}, 16'h0000},
    '{24'h7C_EEE2, '{MFD_R_FENCE, MFD_S_PC, MFD_F_XOR, MFD_D_A, MFD_P_MEM_RW, MFD_K_ODD},
      16'h3333},
    '{24'h36_DDDD, '{MFD_R_B, MFD_S_SCRATCH_REG_ONE, MFD_F_NOR, MFD_D_B, MFD_P_IO_GROUP_ONE,
      MFD_K_END_OF_OPERATION_SKIP}, VB},
    '{24'h12_C999, '{MFD_R_A, MFD_S_SCRATCH_REG_THREE, MFD_F_AND, MFD_D_FENCE,
      MFD_P_EXTEND_CARRY_TEST_A, MFD_K_COUNTER_DONE_SKIP}, VA},
    '{24'h50_B888, '{MFD_R_Q, MFD_S_SCRATCH_REG_FOUR, MFD_F_ADD, MFD_D_PC,
      MFD_P_EXTEND_CARRY_TEST_B, MFD_K_COUNTER_DONE_BUMP_SKIP}, 16'h4444},
    '{24'hC6_A333, '{MFD_R_NONE, MFD_S_M, MFD_F_SUM_OVERFLOW_VARIANT, MFD_D_INSTRUCTION_REG,
      MFD_P_LOOP_COUNT_LOAD, MFD_K_NEGATIVE_SKIP}, 16'h0000},
    '{24'hEF_7777, '{MFD_R_NONE, MFD_S_QUALIFIED_SOURCE, MFD_F_CIRCULAR_RIGHT_SHIFT,
      MFD_D_SCRATCH_REG_ONE, MFD_P_SPECIAL_LOAD_ENABLE, MFD_K_TEST_BIT_ZERO}, 16'h0000},
    '{24'hEB_5555, '{MFD_R_NONE, MFD_S_LOOP_COUNT_REGISTER, MFD_F_MICRO_RETURN,
      MFD_D_SCRATCH_REG_THREE, MFD_P_SHIFT_ROTATE_GROUP_TWO, MFD_K_OVERFLOW_SKIP}, 16'h0000},
    '{24'hE1_0000, '{MFD_R_NONE, MFD_S_INTERRUPT_CODE_REGISTER, MFD_F_MICRO_SUBROUTINE_CALL,
      MFD_D_IO_OUTPUT_BUS, MFD_P_REVERSE_SKIP_SENSE, MFD_K_BUMP_COUNT_SKIP}, 16'h0000},
    '{24'hF5_AAAA, '{MFD_R_NONE, MFD_S_SCRATCH_REG_TWO, MFD_F_WORD_FLAG_LOAD, MFD_D_Q,
      MFD_P_ALTER_SKIP_GROUP_ONE, MFD_K_NO_PROTECT_VIOLATION_SKIP}, 16'h0000},
    '{24'h03_32BE, '{MFD_R_A, MFD_S_IO_INPUT_BUS, MFD_F_MICROJUMP, MFD_D_T,
      MFD_P_ALTER_SKIP_GROUP_TWO, MFD_K_ALWAYS_SKIP}, VA},
    '{24'h24_9126, '{MFD_R_B, MFD_S_T, MFD_F_INC, MFD_D_M, MFD_P_RIGHT_BY_ONE,
      MFD_K_FLAG_SKIP}, VB},
    '{24'hCD_1611, '{MFD_R_NONE, MFD_S_NONE, MFD_F_MICRO_SUBROUTINE_CALL,
      MFD_D_SCRATCH_REG_TWO, MFD_P_LEFT_BY_ONE, MFD_K_REPEAT_SKIP}, 16'h0000},
    '{24'h7A_F4CB, '{MFD_R_FENCE, MFD_S_NONE, MFD_F_NONE, MFD_D_SCRATCH_REG_FOUR, MFD_P_NONE,
      MFD_K_NONE}, 16'h3333}};

  mfd_store_model #(.A_VAL(VA), .B_VAL(VB)) mfd_store_model_inst (.*);
  mfd_decoder mfd_decoder_inst (.*);

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Compares a decoded selection set.
  task automatic chk_dec(input mfd_decode_s got, input mfd_decode_s exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t decode %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a data value.
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // One AXI4-Lite transfer, write when we is set; waits for the response.
  task automatic axi(input logic we, input logic [3:0] a, input logic [31:0] d);
    logic pend;
    pend = 1'b1;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    while (pend) begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        pend = 1'b0;
        resp = we ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'h0;
      end
    end
  endtask

  // Presents one word with flags {a, b, bit11} and returns once it is decoded.
  task automatic put(input logic [23:0] w, input logic v, input logic [2:0] q);
    @(posedge mclk);
    {pm_word, pm_valid} <= {w, v};
    {addr_a_ff, addr_b_ff, instruction_reg_bit11} <= q;
    @(posedge mclk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    {rst_n, pm_word, pm_valid, addr_a_ff, addr_b_ff, instruction_reg_bit11} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    axi(1'b0, `MFD_OFS_CTRL, 32'h0000_0000);
    chk_v(rd, 32'(`MFD_CTRL_RST));
    axi(1'b0, `MFD_OFS_COUNT, 32'h0000_0000);
    chk_v(rd, 32'h0000_0000);
    axi(1'b0, 4'hC, 32'h0000_0000);
    chk_v(32'(resp), 32'(`MFD_RESP_SLVERR));
    // Rows go back to back, one word each cycle.
    for (int i = 0; i <= 14; i++) begin
      @(posedge mclk);
      pm_valid <= 1'b1;
      if (i < 14)
        pm_word <= rows[i].w;
      #1;
      if (i > 0) begin
        chk_dec(decode, rows[i-1].d);
        chk_v(32'(rbus_data), 32'(rows[i-1].r));
      end
    end
    put(24'hBF_FFFF, 1'b1, 3'h4);
    chk_v(32'({decode.rsrc, rbus_data}), 32'({MFD_R_A, VA}));
    put(24'hBF_FFFF, 1'b1, 3'h2);
    chk_v(32'({decode.rsrc, rbus_data}), 32'({MFD_R_B, VB}));
    put(24'hBF_FFFF, 1'b1, 3'h0);
    chk_v(32'({decode.rsrc, rbus_data}), 32'({MFD_R_A, VA}));
    put(24'hAF_FFFF, 1'b1, 3'h0);
    chk_v(32'({decode.rsrc, rbus_data}), 32'h0000_0000);
    put(24'h9F_FFFF, 1'b1, 3'h0);
    chk_v(32'({decode.rsrc, rbus_data}), 32'({MFD_R_A, VA}));
    put(24'h9F_FFFF, 1'b1, 3'h1);
    chk_v(32'({decode.rsrc, rbus_data}), 32'({MFD_R_B, VB}));
    put(24'hFF_FFFF, 1'b0, 3'h0);
    chk_dec(decode, '0);
    axi(1'b0, `MFD_OFS_LAST, 32'h0000_0000);
    chk_v(rd, 32'h009F_FFFF);
    axi(1'b1, `MFD_OFS_CTRL, 32'h0000_0000);
    chk_v(32'(resp), 32'(`MFD_RESP_OKAY));
    put(24'hFF_FFFF, 1'b1, 3'h0);
    chk_dec(decode, '0);
    axi(1'b1, `MFD_OFS_COUNT, 32'h0000_0001);
    chk_v(32'(resp), 32'(`MFD_RESP_SLVERR));
    // Fourteen rows, six flag words twice each and one trailing word were taken.
    axi(1'b0, `MFD_OFS_COUNT, 32'h0000_0000);
    chk_v(rd, 32'h0000_001B);
    // A reset in mid-run clears the decode and restores the enable.
    @(posedge mclk);
    rst_n <= 1'b0;
    put(24'h7C_EEE2, 1'b1, 3'h0);
    chk_dec(decode, '0);
    chk_v(32'(rbus_data), 32'h0000_0000);
    @(posedge mclk);
    rst_n <= 1'b1;
    axi(1'b0, `MFD_OFS_CTRL, 32'h0000_0000);
    chk_v(rd, 32'(`MFD_CTRL_RST));
    tally_and_finish();
  end
endmodule
